/* msh_top.sv */
/*
  handshake and command logic of a stepping motor driver: ready and pulse-ready
  outputs, operation select capture, jog/stop/free/preset/home commands and lamp.
  assumes the motion engine reports motion_done and the position counter; pulse
  train edges arrive as one-cycle strobes; mode straps are caught after reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "msh_consts.svh"
module msh_top
  import msh_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = `MSH_BLINK_CYCLES
)
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  ctrl_supply_ok,
  input  wire logic                  main_supply_ok,
  input  wire logic                  pulse_mode_strap,
  input  wire logic                  pulse_scheme_switch,
  input  wire logic                  start,
  input  wire logic [`MSH_SEL_W-1:0] op_select,
  input  wire logic                  pulse_strobe,
  input  wire logic                  pulse_dir_fwd,
  input  wire logic                  pulse_active,
  input  wire logic                  motion_done,
  input  wire logic                  remote_enable,
  input  wire msh_cmd_s              cmd,
  input  wire logic [`MSH_POS_W-1:0] actual_pos,
  output logic                       ready,
  output logic                       pulse_accept_ok,
  output logic                       motor_excite,
  output logic                       lamp_red,
  output logic                       lamp_green,
  output logic                       home_store,
  output logic                       scheme_one_pulse,
  output msh_motion_s                motion,
  output logic [`MSH_POS_W-1:0]      command_pos,
  output logic [`MSH_POS_W-1:0]      home_pos
);

  msh_state_s q;
  msh_state_s next_q;
  logic       start_rise;
  logic       any_jog;

  assign start_rise = start & ~q.start_d;
  assign any_jog    = cmd.fwd_high | cmd.fwd_norm | cmd.fwd_step
                    | cmd.rev_high | cmd.rev_norm | cmd.rev_step;

  // next state of the whole block
  always_comb
  begin
    next_q            = q;
    next_q.start_d    = start;
    next_q.store_home = 1'b0;
    next_q.powered    = ctrl_supply_ok & main_supply_ok;
    // mode and scheme latched only at power-up or on the first powered cycle after reset
    if (!q.powered && ctrl_supply_ok && main_supply_ok)
    begin
      next_q.pulse_mode = pulse_mode_strap;
      next_q.scheme_one = (pulse_scheme_switch != `MSH_SCHEME_TWO);
    end
    // free drops excitation, clearing restores it
    next_q.excite = ~cmd.free;
    // preset takes present position as home
    if (remote_enable && cmd.preset)
    begin
      next_q.home_pos   = actual_pos;
      next_q.store_home = 1'b1;
    end
    // both lamp elements blink together while remote
    if (remote_enable)
    begin
      if (q.blink_cnt >= BLINK_CYCLES - 1)
      begin
        next_q.blink_cnt  = 32'h0000_0000;
        next_q.lamp_red   = ~q.lamp_red;
      end
      else
      begin
        next_q.blink_cnt = q.blink_cnt + 32'h0000_0001;
      end
      // green mirrors red from the first remote cycle, so no odd phase at entry
      next_q.lamp_green = next_q.lamp_red;
    end
    else
    begin
      next_q.blink_cnt  = 32'h0000_0000;
      next_q.lamp_red   = 1'b0;
      next_q.lamp_green = next_q.powered;
    end
    // command position follows the motor, from the home reference
    next_q.cmd_pos = actual_pos - q.home_pos;
    case (q.st)
      MSH_IDLE:
      begin
        // ready once both supplies are present
        next_q.ready           = next_q.powered;
        next_q.pulse_accept_ok = next_q.powered & next_q.pulse_mode; // in pulse mode, rises with ready at power-up
        next_q.mot.run         = 1'b0;
        if (q.powered)
        begin
          if (!q.pulse_mode && start_rise && q.ready)
          begin
            // capture select lines at start edge
            next_q.mot.op_sel      = op_select;
            next_q.mot.run         = 1'b1;
            next_q.mot.home_return = 1'b0;
            next_q.mot.step_only   = 1'b0;
            next_q.ready           = 1'b0;
            next_q.st              = MSH_RUN;
          end
          else if (q.pulse_mode && pulse_strobe)
          begin
            next_q.mot.run     = 1'b1;
            next_q.mot.dir_fwd = pulse_dir_fwd;
            next_q.ready       = 1'b0;
            next_q.st          = MSH_RUN;
          end
          else if (remote_enable && (cmd.home || any_jog) && !cmd.stop)
          begin
            next_q.mot.run         = 1'b1;
            next_q.mot.home_return = cmd.home;
            next_q.mot.dir_fwd     = cmd.fwd_high | cmd.fwd_norm | cmd.fwd_step;
            next_q.mot.speed_high  = cmd.fwd_high | cmd.rev_high;
            next_q.mot.step_only   = cmd.fwd_step | cmd.rev_step;
            next_q.ready           = 1'b0;
            next_q.st              = MSH_RUN;
          end
        end
      end
      MSH_RUN:
      begin
        if (remote_enable && cmd.stop)
        begin
          next_q.mot.run = 1'b0;
          next_q.st      = MSH_SETTLE;
        end
        // wait for pulse train to stop
        else if (motion_done && !(q.pulse_mode && pulse_active))
        begin
          next_q.mot.run = 1'b0;
          next_q.st      = MSH_SETTLE;
        end
      end
      MSH_SETTLE:
      begin
        // home return leaves command position at zero
        if (q.mot.home_return)
        begin
          next_q.cmd_pos = `MSH_POS_ZERO;
        end
        next_q.mot.home_return = 1'b0;
        // ready returns once finished and, in controller mode, start is released
        if (q.pulse_mode || !start)
        begin
          next_q.ready = q.powered;
          next_q.st    = MSH_IDLE;
        end
      end
      default:
      begin
        next_q.st = MSH_IDLE;
      end
    endcase
    // losing supply drops ready, pulse_accept_ok and run, and returns to idle
    if (!next_q.powered)
    begin
      next_q.ready           = 1'b0;
      next_q.pulse_accept_ok = 1'b0;
      next_q.mot.run         = 1'b0;
      next_q.st              = MSH_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q       <= '0;
      q.st    <= MSH_IDLE;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign ready            = q.ready;
  assign pulse_accept_ok  = q.pulse_accept_ok;
  assign motor_excite     = q.excite;
  assign lamp_red         = q.lamp_red;
  assign lamp_green       = q.lamp_green;
  assign home_store       = q.store_home;
  assign scheme_one_pulse = q.scheme_one;
  assign motion           = q.mot;
  assign command_pos      = q.cmd_pos;
  assign home_pos         = q.home_pos;

  // a start edge in controller mode drops ready next cycle
  chk_start_drops_ready: assert property (@(posedge clk) disable iff (reset)
    (q.st == MSH_IDLE && q.powered && !q.pulse_mode && q.ready && start_rise) |=> !ready)
    else $error("ready did not drop after start");
  chk_select_held: assert property (@(posedge clk) disable iff (reset)
    (q.st == MSH_RUN) |=> (q.st != MSH_RUN) || $stable(motion.op_sel))
    else $error("select changed during motion");
  // stop ends run within one cycle
  chk_stop_halts: assert property (@(posedge clk) disable iff (reset)
    (q.st == MSH_RUN && remote_enable && cmd.stop) |=> !motion.run)
    else $error("stop did not halt motion");
  chk_free_excite: assert property (@(posedge clk) disable iff (reset)
    cmd.free |=> !motor_excite)
    else $error("free did not drop excitation");
  // no ready while pulses still active in run
  chk_pulse_ready: assert property (@(posedge clk) disable iff (reset)
    (q.st == MSH_RUN && q.pulse_mode && pulse_active) |=> !ready)
    else $error("ready while pulses active");
  chk_lamp_together: assert property (@(posedge clk) disable iff (reset)
    (remote_enable && $past(remote_enable) && $past(remote_enable, 2)) |-> lamp_red == lamp_green)
    else $error("lamp elements out of step");
  chk_home_zero: assert property (@(posedge clk) disable iff (reset)
    (q.st == MSH_SETTLE && q.mot.home_return) |=> command_pos == `MSH_POS_ZERO)
    else $error("command position not zero after home");
  // preset stores home and pulses store
  chk_preset_store: assert property (@(posedge clk) disable iff (reset)
    (remote_enable && cmd.preset) |=> home_store && home_pos == $past(actual_pos))
    else $error("preset not stored");
  chk_ready_power: assert property (@(posedge clk) disable iff (reset)
    ready |-> q.powered)
    else $error("ready without supplies");

  cov_ctrl_start: cover property (@(posedge clk) disable iff (reset)
    start_rise && ready && !q.pulse_mode ##[1:20] ready);
  cov_pulse_run: cover property (@(posedge clk) disable iff (reset)
    pulse_strobe && pulse_accept_ok);
  cov_home_run: cover property (@(posedge clk) disable iff (reset)
    remote_enable && cmd.home && ready);
  cov_stop_run: cover property (@(posedge clk) disable iff (reset)
    q.st == MSH_RUN && cmd.stop && remote_enable);

endmodule : msh_top
`default_nettype wire

/* msh_consts.svh */
/*
  constants for the motion start handshake block: lamp timing, command widths.
  assumes a single 125 MHz clock and synchronous inputs.
*/
// Notes on behaviour
// - controller mode: ready rises once both supplies present and idle.
// - ready drops as motion begins; host holds start until it sees ready low.
// - controller mode: ready returns when the selected positioning finishes.
// - pulse mode: ready and pulse_accept_ok rise after both supplies present.
// - pulse mode: ready only after pulses stop and motion completes.
// - remote operation: red and green lamp elements blink together.
// - fast home return drives to home; command position then reads zero.
// - jog: high speed, normal speed, single minimum step, both directions.
// - remote stop halts any motion at once.
// - free removes excitation; clearing free restores it.
// - position preset takes present position as home and stores it.
// - pulse scheme switch: off two-pulse, on one-pulse.
// - pulse scheme change takes effect only after a power cycle; the code also latches it on the first powered cycle after reset.
`ifndef MSH_CONSTS_SVH
`define MSH_CONSTS_SVH
`define MSH_CLK_MHZ        125
`define MSH_BLINK_MS       250
`define MSH_BLINK_CYCLES   (`MSH_BLINK_MS * 1000 * `MSH_CLK_MHZ)
`define MSH_POS_W          32
`define MSH_SEL_W          3
`define MSH_POS_ZERO       32'h0000_0000
`define MSH_SEL_ZERO       3'h0
`define MSH_STEP_ONE       32'h0000_0001
`define MSH_SCHEME_TWO     1'b0
`endif

/* msh_pkg.sv */
/*
  types for the motion start handshake block.
  assumes msh_consts.svh for widths.
*/
`include "msh_consts.svh"
package msh_pkg;
  // motion state, gray coded along idle -> run -> settle
  typedef enum logic [1:0]
  {
    MSH_IDLE   = 2'b00,
    MSH_RUN    = 2'b01,
    MSH_SETTLE = 2'b11,
    MSH_SPARE  = 2'b10
  } msh_state_e;

  // jog and remote commands, one bit each
  typedef struct packed
  {
    logic fwd_high;
    logic fwd_norm;
    logic fwd_step;
    logic rev_high;
    logic rev_norm;
    logic rev_step;
    logic stop;
    logic free;
    logic preset;
    logic home;
  } msh_cmd_s;

  // motor-side request
  typedef struct packed
  {
    logic                    run;
    logic                    dir_fwd;
    logic                    speed_high;
    logic                    step_only;
    logic                    home_return;
    logic [`MSH_SEL_W-1:0]   op_sel;
  } msh_motion_s;

  // whole state of the module
  typedef struct packed
  {
    msh_state_e              st;
    logic                    pulse_mode;
    logic                    scheme_one;
    logic                    powered;
    logic                    ready;
    logic                    pulse_accept_ok;
    logic                    start_d;
    logic                    excite;
    logic                    lamp_red;
    logic                    lamp_green;
    logic                    store_home;
    logic [31:0]             blink_cnt;
    logic [`MSH_POS_W-1:0]   cmd_pos;
    logic [`MSH_POS_W-1:0]   home_pos;
    msh_motion_s             mot;
  } msh_state_s;
endpackage : msh_pkg

/* msh_host_model.sv */
/*
  host stand-in: start handshake with the operation select lines.
  assumes ready from the block and go and go_sel from the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module msh_host_model
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       go,
  input  wire logic [2:0] go_sel,
  input  wire logic       ready,
  output logic            start,
  output logic [2:0]      op_select
);
  // raise start with a select; once ready falls, drop it and scramble the select lines in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      start     <= 1'b0;
      op_select <= 3'h0;
    end
    else if (go && ready && !start)
    begin
      start     <= 1'b1;
      op_select <= go_sel;
    end
    else if (start && !ready)
    begin
      start     <= 1'b0;
      op_select <= ~op_select;
    end
  end
endmodule : msh_host_model
`default_nettype wire

/* motion_start_handshake_tb_top.sv */
/*
  self-checking bench: power-up, start handshake, remote commands, lamp, pulse mode.
  assumes msh_host_model as the host; the bench plays the motion engine.
*/
`timescale 1ns/1ns
`default_nettype none
module motion_start_handshake_tb_top
  import msh_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b1, ctrl_ok = 1'b0, main_ok = 1'b0, strap = 1'b0;
  logic        scheme_sw = 1'b0, go = 1'b0, strobe = 1'b0, p_dir = 1'b0, p_active = 1'b0;
  logic        md = 1'b0, remote = 1'b0, start, ready, pok, excite, red, green, hstore, sch1;
  logic        prev_red, dir_exp;
  logic [2:0]  go_sel = 3'h0, sel, sel_exp;
  logic [31:0] apos = 32'h0, cpos, hpos, apos_exp;
  msh_cmd_s    cmd = '0;
  msh_motion_s mot;
  int          err_count = 0, num_checks = 0, seed, toggles, stores;

  // 8 ns clock
  always #4 clk = ~clk;

  msh_host_model msh_host_model_inst
  (
    .clk(clk), .reset(reset), .go(go), .go_sel(go_sel), .ready(ready), .start(start), .op_select(sel)
  );

  msh_top #(.BLINK_CYCLES(4)) msh_top_inst
  (
    .clk(clk), .reset(reset), .ctrl_supply_ok(ctrl_ok), .main_supply_ok(main_ok),
    .pulse_mode_strap(strap), .pulse_scheme_switch(scheme_sw), .start(start), .op_select(sel),
    .pulse_strobe(strobe), .pulse_dir_fwd(p_dir), .pulse_active(p_active), .motion_done(md),
    .remote_enable(remote), .cmd(cmd), .actual_pos(apos), .ready(ready), .pulse_accept_ok(pok),
    .motor_excite(excite), .lamp_red(red), .lamp_green(green), .home_store(hstore),
    .scheme_one_pulse(sch1), .motion(mot), .command_pos(cpos), .home_pos(hpos)
  );

  // expected run, direction, high speed and single step of jog i
  function automatic logic [3:0] jog_exp(input int i);
    return {1'b1, i < 3, i % 3 == 0, i % 3 == 2};
  endfunction : jog_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wait_rdy(input logic lvl);
    int i;
    i = 0;
    while (ready !== lvl && i < 300)
    begin
      @(posedge clk);
      i++;
    end
    chk(ready, lvl);
  endtask : wait_rdy

  task automatic power(input logic on);
    @(posedge clk);
    ctrl_ok <= on;
    main_ok <= on;
  endtask : power

  task automatic end_of_test();
    $display("checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // watchdog
  initial
  begin
    #200000;
    err_count++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    seed = 32'hA74F5BA0;
    cyc(16);
    reset <= 1'b0;
    ctrl_ok <= 1'b1;
    cyc(6);
    chk(ready, 1'b0);
    power(1'b1);
    wait_rdy(1'b1);
    chk({pok, red, green, excite}, 4'h3);
    repeat (4)
    begin
      sel_exp = 3'($random(seed));
      go_sel <= sel_exp;
      go <= 1'b1;
      md <= 1'b0;
      wait_rdy(1'b0);
      go <= 1'b0;
      cyc(2 + ($random(seed) & 7));
      chk(mot.op_sel, sel_exp);
      chk({ready, mot.run}, 2'h1);
      md <= 1'b1;
      wait_rdy(1'b1);
    end
    remote <= 1'b1;
    cyc(3);
    toggles = 0;
    prev_red = red;
    repeat (16)
    begin
      @(posedge clk);
      chk(red, green);
      toggles += (red !== prev_red);
      prev_red = red;
    end
    chk(toggles > 2, 1);
    for (int i = 0; i < 6; i++)
    begin
      cmd <= msh_cmd_s'(10'h200 >> i);
      md <= 1'b0;
      wait_rdy(1'b0);
      chk({mot.run, mot.dir_fwd, mot.speed_high, mot.step_only}, jog_exp(i));
      cmd <= i[0] ? msh_cmd_s'(10'h000) : msh_cmd_s'(10'h008);
      cyc(2);
      if (!i[0])
        chk(mot.run, 1'b0);
      cmd <= '0;
      md <= 1'b1;
      wait_rdy(1'b1);
    end
    cmd <= msh_cmd_s'(10'h004);
    cyc(3);
    chk(excite, 1'b0);
    cmd <= '0;
    cyc(3);
    chk(excite, 1'b1);
    apos_exp = $random(seed);
    apos <= apos_exp;
    cmd <= msh_cmd_s'(10'h002);
    stores = 0;
    repeat (6)
    begin
      @(posedge clk);
      cmd <= '0;
      stores += hstore;
    end
    chk(stores, 1);
    chk(hpos, apos_exp);
    chk(cpos, 32'h0);
    apos <= apos_exp + 32'h1234;
    cyc(3);
    chk(cpos, 32'h1234);
    cmd <= msh_cmd_s'(10'h001);
    md <= 1'b0;
    wait_rdy(1'b0);
    chk(mot.home_return, 1'b1);
    cmd <= '0;
    apos <= apos_exp;
    md <= 1'b1;
    wait_rdy(1'b1);
    cyc(2);
    chk(cpos, 32'h0);
    remote <= 1'b0;
    cyc(3);
    chk({red, green}, 2'h1);
    reset <= 1'b1;
    strap <= 1'b1;
    scheme_sw <= 1'b1;
    ctrl_ok <= 1'b0;
    main_ok <= 1'b0;
    cyc(4);
    reset <= 1'b0;
    cyc(2);
    power(1'b1);
    wait_rdy(1'b1);
    chk({pok, sch1}, 2'h3);
    scheme_sw <= 1'b0;
    md <= 1'b0;
    p_active <= 1'b1;
    // pulses sent only after pulse_accept_ok seen high
    dir_exp = 1'($random(seed));
    repeat (3)
    begin
      @(posedge clk);
      strobe <= 1'b1;
      p_dir <= dir_exp;
      @(posedge clk);
      strobe <= 1'b0;
    end
    chk(ready, 1'b0);
    chk(mot.dir_fwd, dir_exp);
    md <= 1'b1;
    cyc(4);
    chk(ready, 1'b0);
    p_active <= 1'b0;
    wait_rdy(1'b1);
    chk(sch1, 1'b1);
    power(1'b0);
    cyc(3);
    power(1'b1);
    wait_rdy(1'b1);
    chk(sch1, 1'b0);
    end_of_test();
  end
endmodule : motion_start_handshake_tb_top
`default_nettype wire
